// ---- dv/dsln_loop_model.sv ----
/*
 * Behavioural chain of up to ten inverting dynamic sensors.
 * Assumes the bench picks the sensor count and can open the loop.
 */
`timescale 1ns/100ps
module dsln_loop_model
(
    input  wire logic       loop_in,
    input  wire logic [3:0] n_sensors_in,
    input  wire logic       open_in,
    output logic            loop_ret_out
);
    logic [10:0] stage;

    // walk the waveform through the fitted sensors; open loop pulls down
    // sensors invert
    always_comb
    begin
        stage[0] = loop_in;
        for (int k = 1; k <= 10; k++)
            stage[k] = ~stage[k-1];
        loop_ret_out = open_in ? 1'h0 : stage[n_sensors_in];
    end
endmodule

// ---- dv/test_dsln_node.sv ----
/*
 * Self-checking bench for the dynamic safety loop node.
 * Assumes shortened waveform and reset window parameters.
 */
`timescale 1ns/100ps
`include "dsln_params.svh"
module test_dsln_node;
    localparam int HALF = 40;
    localparam int SETL = 8;
    localparam int WIN  = 50;
    logic                      mclk_in    = 1'h0;
    logic                      rstn_in    = 1'h0;
    dsln_pkg::dsln_cfg_type    cfg        = '0;
    logic                      btn        = 1'h0;
    logic [`DSLN_NUM_OUT-1:0]  cmd        = '0;
    logic                      addr_wr    = 1'h0;
    logic [`DSLN_ADDR_W-1:0]   addr       = '0;
    logic [3:0]                n_sens     = 4'hA;
    logic                      open_loop  = 1'h0;
    logic                      loop_out;
    logic                      loop_ret;
    logic                      loop_ok;
    logic                      safe_en;
    logic [`DSLN_NUM_OUT-1:0]  out_pin;
    logic [`DSLN_ADDR_W-1:0]   slave_addr;
    int                        n_mismatch = 0;
    int                        total_checks = 0;
    int                        i;
    int                        len;

    // free running clock
    always #2.5 mclk_in = ~mclk_in;

    dsln_node #(.HALF_CYC(HALF), .SETTLE_CYC(SETL), .WIN_CYC(WIN)) dsln_node_inst (
        .mclk_in(mclk_in), .rstn_in(rstn_in), .cfg_in(cfg), .loop_ret_in(loop_ret),
        .reset_btn_in(btn), .out_cmd_in(cmd), .addr_wr_in(addr_wr), .addr_in(addr),
        .loop_out(loop_out), .loop_ok_out(loop_ok), .safe_enable_out(safe_en),
        .out_pin_out(out_pin), .slave_addr_out(slave_addr));

    dsln_loop_model dsln_loop_model_inst (
        .loop_in(loop_out), .n_sensors_in(n_sens), .open_in(open_loop),
        .loop_ret_out(loop_ret));

    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // wait falling edges
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_in);
    endtask

    // bounded wait for the enable to reach a level
    task automatic wait_en(input logic exp, input int bound);
        for (int k = 0; k < bound && safe_en !== exp; k++)
            cyc(1);
        check({7'h00, safe_en}, {7'h00, exp});
        if (safe_en !== exp)
            final_report();
    endtask

    // bounded measure of one half period of the waveform
    task automatic half_len(output int n);
        logic v;
        v = loop_out;
        for (int k = 0; k < 3 * HALF && loop_out === v; k++)
            cyc(1);
        v = loop_out;
        n = 0;
        while (loop_out === v && n < 3 * HALF)
        begin
            cyc(1);
            n++;
        end
    endtask

    // one local reset pulse of the given length
    task automatic pulse(input int n);
        btn = 1'h1;
        cyc(n);
        btn = 1'h0;
    endtask

    // main sequence
    initial
    begin
        cyc(5);
        rstn_in = 1'h1;
        cyc(1);
        check({3'h0, slave_addr}, 8'h00);
        for (i = 0; i < 8; i++)
        begin
            cmd = i[`DSLN_NUM_OUT-1:0];
            cyc(1);
            check({5'h00, out_pin}, {5'h00, cmd});
        end
        addr = 5'h13;
        addr_wr = 1'h1;
        cyc(1);
        addr_wr = 1'h0;
        addr = 5'h07;
        cyc(2);
        check({3'h0, slave_addr}, 8'h13);
        btn = 1'h1;
        wait_en(1'h1, 3 * HALF + 10);
        check({7'h00, loop_ok}, 8'h01);
        half_len(len);
        check(len[7:0], HALF[7:0]);
        btn = 1'h0;
        wait_en(1'h0, 8);
        btn = 1'h1;
        wait_en(1'h1, 8);
        open_loop = 1'h1;
        wait_en(1'h0, 2 * HALF + SETL + 4);
        check({7'h00, loop_ok}, 8'h00);
        cyc(3 * HALF);
        check({6'h00, loop_ok, safe_en}, 8'h00);
        open_loop = 1'h0;
        wait_en(1'h1, 3 * HALF);
        cfg.odd_count = 1'h1;
        wait_en(1'h0, 2 * HALF + 4);
        n_sens = 4'h9;
        wait_en(1'h1, 3 * HALF);
        open_loop = 1'h1;
        wait_en(1'h0, 2 * HALF + SETL + 4);
        cfg.manual_reset = 1'h1;
        btn = 1'h0;
        open_loop = 1'h0;
        cyc(3 * HALF);
        check({6'h00, loop_ok, safe_en}, 8'h02);
        pulse(WIN + 1);
        cyc(10);
        check({7'h00, safe_en}, 8'h00);
        pulse(WIN);
        wait_en(1'h1, 8);
        open_loop = 1'h1;
        wait_en(1'h0, 2 * HALF + SETL + 4);
        pulse(10);
        cyc(4);
        open_loop = 1'h0;
        cyc(3 * HALF);
        check({6'h00, loop_ok, safe_en}, 8'h02);
        final_report();
    end
endmodule

// ---- rtl/dsln_node.sv ----
/*
 * Dynamic safety loop node: drives a dynamic test waveform through a loop of
 * inverting sensors, checks the return, handles the local reset input and
 * drives the non-safe outputs.
 * Assumes the protocol layer supplies config, output commands and address
 * writes on mclk_in; loop return and reset button are raw pins.
 */
// Operation
// - send test waveform, receive it back
// - sensors invert; compare return against sent
// - parameter picks odd or even polarity
// - check valid with ten sensors
// - test loop over hundred times per second
// - drop enable within 12 ms
// - three outputs follow master bits directly
// - parameter picks automatic or manual reset
// - manual: pulse within 2 s enables
// - slave address zero until readdressed
`timescale 1ns/100ps
`include "dsln_params.svh"
module dsln_node
#(
    parameter int HALF_CYC   = `DSLN_HALF_US * `DSLN_CLK_MHZ,
    parameter int SETTLE_CYC = `DSLN_SETTLE_US * `DSLN_CLK_MHZ,
    parameter int WIN_CYC    = `DSLN_RST_WIN_MS * 1000 * `DSLN_CLK_MHZ
)
(
    input  wire logic                       mclk_in,
    input  wire logic                       rstn_in,
    input  wire dsln_pkg::dsln_cfg_type     cfg_in,
    input  wire logic                       loop_ret_in,
    input  wire logic                       reset_btn_in,
    input  wire logic [`DSLN_NUM_OUT-1:0]   out_cmd_in,
    input  wire logic                       addr_wr_in,
    input  wire logic [`DSLN_ADDR_W-1:0]    addr_in,
    output logic                            loop_out,
    output logic                            loop_ok_out,
    output logic                            safe_enable_out,
    output logic [`DSLN_NUM_OUT-1:0]        out_pin_out,
    output logic [`DSLN_ADDR_W-1:0]         slave_addr_out
);
    localparam int CW  = $clog2(HALF_CYC + 1);
    localparam int RW  = $clog2(WIN_CYC + 2);
    localparam int REACT_CYC = `DSLN_REACT_MS * 1000 * `DSLN_CLK_MHZ;
    localparam int RATE_CYC  = (`DSLN_CLK_MHZ * 1000000) / `DSLN_MIN_TEST_RATE;
    localparam bit TIMING_OK = (HALF_CYC + SETTLE_CYC <= REACT_CYC)
                               && (2 * HALF_CYC < RATE_CYC)
                               && (SETTLE_CYC < HALF_CYC);

    logic [1:0]                 pins_s;
    logic                       ret_s;
    logic                       btn_s;
    logic                       btn_d;
    logic                       next_btn_d;
    logic [CW-1:0]              phase;
    logic [CW-1:0]              next_phase;
    logic                       next_loop;
    logic                       next_loop_ok;
    logic                       good_prev;      // previous sample matched
    logic                       next_good_prev;
    logic                       sample_now;
    logic                       match;
    logic [RW-1:0]              press;
    logic [RW-1:0]              next_press;
    logic                       release_ev;
    logic                       pulse_short;
    dsln_pkg::dsln_state_type   state;
    dsln_pkg::dsln_state_type   next_state;
    logic [`DSLN_NUM_OUT-1:0]   next_out;
    logic [`DSLN_ADDR_W-1:0]    next_addr;

    // pin inputs through two flops
    dsln_sync #(.WIDTH(2)) dsln_sync_inst
    (
        .mclk_in  (mclk_in),
        .rstn_in  (rstn_in),
        .async_in ({reset_btn_in, loop_ret_in}),
        .sync_out (pins_s)
    );
    assign ret_s = pins_s[0];
    assign btn_s = pins_s[1];

    // waveform phase and sampling point
    assign sample_now = (phase == CW'(SETTLE_CYC - 1));
    assign match = (ret_s == (loop_out ^ cfg_in.odd_count));

    always_comb
    begin
        next_phase     = phase + CW'(1);
        next_loop      = loop_out;
        next_loop_ok   = loop_ok_out;
        next_good_prev = good_prev;
        if (phase == CW'(HALF_CYC - 1))
        begin
            next_phase = '0;
            next_loop  = ~loop_out; // toggle each half period
        end
        // two matches in a row
        // a stuck return matches every other sample, so one match is not enough
        if (sample_now)
        begin
            next_good_prev = match;
            next_loop_ok   = match && good_prev;
        end
        if (!rstn_in)
        begin
            next_phase     = '0;
            next_loop      = 1'h0;
            next_loop_ok   = 1'h0;
            next_good_prev = 1'h0;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        phase       <= next_phase;
        loop_out    <= next_loop;
        loop_ok_out <= next_loop_ok;
        good_prev   <= next_good_prev;
    end

    // reset pulse length, saturating past the window
    assign release_ev  = btn_d && !btn_s;
    assign pulse_short = (press <= RW'(WIN_CYC));

    always_comb
    begin
        next_btn_d = btn_s;
        next_press = press;
        if (btn_s && !btn_d)
        begin
            next_press = RW'(1);
        end
        else if (btn_s && (press <= RW'(WIN_CYC)))
        begin
            next_press = press + RW'(1);
        end
        if (!rstn_in)
        begin
            next_btn_d = 1'h0;
            next_press = '0;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        btn_d <= next_btn_d;
        press <= next_press;
    end

    always_comb
    begin
        next_state = state;
        unique case (state)
            dsln_pkg::ST_DISABLED:
            begin
                if (!cfg_in.manual_reset)
                begin
                    if (btn_s && loop_ok_out)
                        next_state = dsln_pkg::ST_ENABLED;
                end
                else if (release_ev && pulse_short && loop_ok_out)
                begin
                    next_state = dsln_pkg::ST_ENABLED;
                end
            end
            dsln_pkg::ST_ENABLED:
            begin
                if (!loop_ok_out || (!cfg_in.manual_reset && !btn_s))
                    next_state = dsln_pkg::ST_DISABLED;
            end
        endcase
        if (!rstn_in)
            next_state = dsln_pkg::ST_DISABLED;
    end

    always_ff @(posedge mclk_in)
    begin
        state <= next_state;
    end

    // enable also gated by current loop status
    assign safe_enable_out = (state == dsln_pkg::ST_ENABLED) && loop_ok_out;

    always_comb
    begin
        next_out  = out_cmd_in;
        next_addr = addr_wr_in ? addr_in : slave_addr_out;
        if (!rstn_in)
        begin
            next_out  = '0;
            next_addr = `DSLN_ADDR_RESET;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        out_pin_out    <= next_out;
        slave_addr_out <= next_addr;
    end

    // checks
    sequence seq_manual_release;
        cfg_in.manual_reset && release_ev && state == dsln_pkg::ST_DISABLED;
    endsequence

    sequence seq_wave_edge;
        phase == CW'(HALF_CYC - 1);
    endsequence

    AST_TIMING: assert property (@(posedge mclk_in) TIMING_OK)
        else $error("test waveform timing out of range");

    AST_LOOP_TOGGLE: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        seq_wave_edge |=> (loop_out != $past(loop_out)))
        else $error("test waveform did not toggle");

    AST_CHECK: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        sample_now |=> (loop_ok_out == ($past(match) && $past(good_prev))))
        else $error("loop status does not follow return check");

    AST_TWO_MATCH: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        sample_now && !good_prev |=> !loop_ok_out)
        else $error("single matching sample marked loop healthy");

    AST_POLARITY: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        sample_now && (ret_s == loop_out) && cfg_in.odd_count |=> !loop_ok_out)
        else $error("odd loop accepted non-inverted return");

    AST_FAULT_DROP: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        !loop_ok_out |-> !safe_enable_out ##1 (state == dsln_pkg::ST_DISABLED))
        else $error("enable held with failed loop");

    AST_OUTS: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        ##1 (out_pin_out == $past(out_cmd_in)))
        else $error("non-safe output does not follow command");

    AST_AUTO: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        state == dsln_pkg::ST_DISABLED && !cfg_in.manual_reset && btn_s && loop_ok_out
        |=> state == dsln_pkg::ST_ENABLED)
        else $error("auto reset did not enable");

    AST_MANUAL_OK: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        seq_manual_release ##0 (pulse_short && loop_ok_out)
        |=> state == dsln_pkg::ST_ENABLED)
        else $error("valid reset pulse did not enable");

    AST_MANUAL_LONG: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        seq_manual_release ##0 !pulse_short |=> state == dsln_pkg::ST_DISABLED)
        else $error("overlong reset pulse enabled");

    AST_ADDR_RESET: assert property (@(posedge mclk_in)
        !rstn_in |=> (slave_addr_out == `DSLN_ADDR_RESET))
        else $error("slave address not zero after reset");
endmodule

// ---- rtl/dsln_params.svh ----
/*
 * Timing figures and reset values for the dynamic safety loop node.
 * Assumes the includer converts the figures to cycles at the core clock rate.
 */
`ifndef DSLN_PARAMS_SVH
`define DSLN_PARAMS_SVH

// core clock rate in MHz
`define DSLN_CLK_MHZ        200
// half period of the dynamic test waveform, in us
`define DSLN_HALF_US        500
// settle time after each waveform edge before the return is sampled, in us
`define DSLN_SETTLE_US      50
// longest off reaction time, in ms
`define DSLN_REACT_MS       12
// longest valid manual reset pulse, in ms
`define DSLN_RST_WIN_MS     2000
// least test rate, in tests per second
`define DSLN_MIN_TEST_RATE  100
// width of the bus slave address
`define DSLN_ADDR_W         5
// bus slave address on delivery
`define DSLN_ADDR_RESET     5'h00
// number of non-safe outputs
`define DSLN_NUM_OUT        3

`endif

// ---- rtl/dsln_pkg.sv ----
/*
 * Types shared by the dynamic safety loop node.
 * Assumes nothing of its surroundings.
 */
package dsln_pkg;

    // node parameters set by the bus master
    typedef struct packed {
        logic odd_count;    // odd number of sensors fitted
        logic manual_reset; // manual reset selected
    } dsln_cfg_type;

    // safe-enable state
    typedef enum logic [0:0] {
        ST_DISABLED = 1'b0,
        ST_ENABLED  = 1'b1
    } dsln_state_type;

endpackage

// ---- rtl/dsln_sync.sv ----
/*
 * Two-flop synchroniser for pin inputs.
 * Assumes the inputs are asynchronous to mclk_in.
 */
`timescale 1ns/100ps
module dsln_sync
#(
    parameter int WIDTH = 2
)
(
    input  wire logic             mclk_in,
    input  wire logic             rstn_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    // two stages, reset to low
    always_comb
    begin
        next_meta = rstn_in ? async_in : '0;
        next_sync = rstn_in ? meta : '0;
    end

    always_ff @(posedge mclk_in)
    begin
        meta     <= next_meta;
        sync_out <= next_sync;
    end
endmodule
